// *** src/dvc_defines.svh ***
// What this block does
// [RULE1] Enabled vector trap forces debug entry
// [RULE2] Trap bit 2 catches fetch at 0x8
// [RULE3] Only exception-entry fetches are trapped
// [RULE4] Vector trap uses no watchpoint comparator
// [RULE5] Control bit 3 enables single-step
// [RULE6] Leave debug, one instruction, re-enter
// [RULE7] Debugger changes step bit only in debug
// [RULE8] Debugger clears step before system access
// [RULE9] Two data registers plus 6-bit handshake
// [RULE10] Handshake read-only, version in 31:28
// [RULE11] Core write sets outbound-full flag
// [RULE12] Debugger data read clears outbound-full
// [RULE13] Debugger write sets inbound-full flag
// [RULE14] Core data read clears inbound-full
// [RULE15] Flags synchronised into both domains
// [RULE16] Coprocessor 14 register decode
// [RULE17] Channel unusable in compressed state
// [RULE18] Core polls outbound-full before writing
// [RULE19] Debugger waits while inbound-full set
// [RULE20] Two active-high channel request outputs
// [RULE21] 39-bit chain reaches control coprocessor
// [RULE22] 8-bit vector trap register layout
// [RULE23] 4-bit debug control at 0b00000
// [RULE24] Two-stage synchroniser on every flag
`ifndef DVC_DEFINES_SVH
`define DVC_DEFINES_SVH

// ----------------------------------------
// Debug register map (scan side)
// ----------------------------------------
`define DVC_ADR_CTRL       5'h00
`define DVC_ADR_STAT       5'h01
`define DVC_ADR_VCATCH     5'h02
`define DVC_ADR_COMMS_CTL  5'h04
`define DVC_ADR_COMMS_DATA 5'h05

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DVC_CTRL_W         4
`define DVC_CTRL_STEP      3
`define DVC_CTRL_INT_DIS   2
`define DVC_CTRL_DBG_REQ   1
`define DVC_CTRL_DBG_ACK   0
`define DVC_CTRL_RST       4'h0
`define DVC_VC_W           8
`define DVC_VC_RST         8'h00
`define DVC_VC_WMASK       8'hdf
`define DVC_HS_VER_LSB     28
`define DVC_HS_TXF         1
`define DVC_HS_RXF         0

// ----------------------------------------
// Coprocessor 14 decode and vectors
// ----------------------------------------
`define DVC_CRN_HS         4'h0
`define DVC_CRN_DATA       4'h1
`define DVC_CRM_COMMS      4'h0
`define DVC_VEC_SOFT_ADDR  32'h0000_0008
`define DVC_C15_LEN        39
`define DVC_C15_RW         38

`endif

// *** src/dvc_pkg.sv ***
package dvc_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_RUN,
    ST_BREAK
  } dvc_step_t;

  // Handshake word, shared by core and scan reads
  function automatic logic [31:0] dvc_hs_word(input logic [3:0] ver,
                                              input logic       txf,
                                              input logic       rxf);
    dvc_hs_word = {ver, 26'h0, txf, rxf};
  endfunction

endpackage

// *** src/dvc_cross_if.sv ***
`timescale 1ns/1ps
// Signals crossing between the core and scan clock domains
interface dvc_cross_if;
  logic [3:0]  ctrl;
  logic [7:0]  vcatch;
  logic        rx_set_tgl;
  logic [31:0] rx_data;
  logic        tx_clr_tgl;
  logic        c15_req_tgl;
  logic [38:0] c15_word;
  logic        tx_set_tgl;
  logic [31:0] tx_data;
  logic        rx_clr_tgl;
  logic        c15_ack_tgl;
  logic [31:0] c15_rdata;
  logic        dbg_ack;

  modport scan (output ctrl, vcatch, rx_set_tgl, rx_data, tx_clr_tgl, c15_req_tgl, c15_word,
                input  tx_set_tgl, tx_data, rx_clr_tgl, c15_ack_tgl, c15_rdata, dbg_ack);
  modport core (input  ctrl, vcatch, rx_set_tgl, rx_data, tx_clr_tgl, c15_req_tgl, c15_word,
                output tx_set_tgl, tx_data, rx_clr_tgl, c15_ack_tgl, c15_rdata, dbg_ack);
endinterface

// *** src/dvc_scan.sv ***
`timescale 1ns/1ps
`include "dvc_defines.svh"
// Scan-clock side: debug register file and control coprocessor chain
module dvc_scan import dvc_pkg::*; #(
  parameter logic [3:0] VERSION = 4'h5  // Version code value is arbitrary
) (
  input  wire logic        tck,
  input  wire logic        arst_n,
  dvc_cross_if.scan        cr,
  input  wire logic [4:0]  sc_addr,
  input  wire logic        sc_wr,
  input  wire logic        sc_rd,
  input  wire logic [31:0] sc_wdata,
  output logic      [31:0] sc_rdata,
  input  wire logic        sc15_valid,
  input  wire logic [38:0] sc15_word,
  output logic             sc15_busy,
  output logic             sc15_done,
  output logic      [31:0] sc15_rdata
);

  logic [3:0]  s1_q, s2_q;
  logic [3:0]  ctrl_q, ctrl_d;
  logic [7:0]  vc_q, vc_d;
  logic [31:0] rx_data_q, rx_data_d, rdata_q, rdata_d, c15r_q, c15r_d;
  logic [38:0] c15w_q, c15w_d;
  logic        rx_set_q, rx_set_d, tx_clr_q, tx_clr_d, req_q, req_d;
  logic        busy_q, busy_d, seen_q, seen_d, done_q, done_d;
  logic        tx_full, rx_full, ack_s, dbg_s;

  // [RULE15] flags seen on scan clock
  assign tx_full = s2_q[0] ^ tx_clr_q;
  assign rx_full = rx_set_q ^ s2_q[1];
  assign ack_s   = s2_q[2];
  assign dbg_s   = s2_q[3];

  // Next state of the scan-side registers
  always_comb begin
    ctrl_d    = ctrl_q;
    vc_d      = vc_q;
    rx_data_d = rx_data_q;
    rx_set_d  = rx_set_q;
    tx_clr_d  = tx_clr_q;
    rdata_d   = rdata_q;
    req_d     = req_q;
    c15w_d    = c15w_q;
    busy_d    = busy_q;
    seen_d    = seen_q;
    c15r_d    = c15r_q;
    done_d    = 1'b0;
    if (sc_wr) begin
      // [RULE23] control register write
      if (sc_addr == `DVC_ADR_CTRL) begin
        ctrl_d = sc_wdata[3:0];
      // [RULE22] reserved trap bit kept clear
      end else if (sc_addr == `DVC_ADR_VCATCH) begin
        vc_d = sc_wdata[7:0] & `DVC_VC_WMASK;
      // [RULE13] debugger write sets inbound-full
      end else if (sc_addr == `DVC_ADR_COMMS_DATA && !rx_full) begin
        rx_data_d = sc_wdata;
        rx_set_d  = ~rx_set_q;
      end
    end
    if (sc_rd) begin
      if (sc_addr == `DVC_ADR_CTRL) begin
        rdata_d = {28'h0, ctrl_q};
      end else if (sc_addr == `DVC_ADR_STAT) begin
        rdata_d = {30'h0, ctrl_q[`DVC_CTRL_DBG_REQ], dbg_s};
      end else if (sc_addr == `DVC_ADR_VCATCH) begin
        rdata_d = {24'h0, vc_q};
      end else if (sc_addr == `DVC_ADR_COMMS_CTL) begin
        rdata_d = dvc_hs_word(VERSION, tx_full, rx_full);
      end else if (sc_addr == `DVC_ADR_COMMS_DATA) begin
        rdata_d = cr.tx_data;
        // [RULE12] scan read frees outbound
        if (tx_full) begin
          tx_clr_d = ~tx_clr_q;
        end
      end else begin
        rdata_d = 32'h0;
      end
    end
    // [RULE21] chain access only in debug state
    if (sc15_valid && !busy_q && dbg_s) begin
      c15w_d = sc15_word;
      req_d  = ~req_q;
      busy_d = 1'b1;
    end else if (busy_q && ack_s != seen_q) begin
      seen_d = ack_s;
      busy_d = 1'b0;
      done_d = 1'b1;
      c15r_d = cr.c15_rdata;
    end
  end

  // Registers; first sync stage feeds only the second
  always_ff @(posedge tck or negedge arst_n) begin
    if (!arst_n) begin
      s1_q      <= 4'h0;
      s2_q      <= 4'h0;
      ctrl_q    <= `DVC_CTRL_RST;
      vc_q      <= `DVC_VC_RST;
      rx_data_q <= 32'h0;
      rx_set_q  <= 1'b0;
      tx_clr_q  <= 1'b0;
      rdata_q   <= 32'h0;
      req_q     <= 1'b0;
      c15w_q    <= 39'h0;
      busy_q    <= 1'b0;
      seen_q    <= 1'b0;
      c15r_q    <= 32'h0;
      done_q    <= 1'b0;
    end else begin
      // [RULE24] two-stage synchroniser
      s1_q      <= {cr.dbg_ack, cr.c15_ack_tgl, cr.rx_clr_tgl, cr.tx_set_tgl};
      s2_q      <= s1_q;
      ctrl_q    <= ctrl_d;
      vc_q      <= vc_d;
      rx_data_q <= rx_data_d;
      rx_set_q  <= rx_set_d;
      tx_clr_q  <= tx_clr_d;
      rdata_q   <= rdata_d;
      req_q     <= req_d;
      c15w_q    <= c15w_d;
      busy_q    <= busy_d;
      seen_q    <= seen_d;
      c15r_q    <= c15r_d;
      done_q    <= done_d;
    end
  end

  assign cr.ctrl        = ctrl_q;
  assign cr.vcatch      = vc_q;
  assign cr.rx_set_tgl  = rx_set_q;
  assign cr.rx_data     = rx_data_q;
  assign cr.tx_clr_tgl  = tx_clr_q;
  assign cr.c15_req_tgl = req_q;
  assign cr.c15_word    = c15w_q;
  assign sc_rdata       = rdata_q;
  assign sc15_busy      = busy_q;
  assign sc15_done      = done_q;
  assign sc15_rdata     = c15r_q;

  default clocking @(posedge tck); endclocking
  default disable iff (!arst_n);

  a_scan_tx_clear: assert property (sc_rd && sc_addr == `DVC_ADR_COMMS_DATA && tx_full
    |=> !tx_full) else $error("outbound flag not cleared by scan read"); // [RULE12]
  a_c15_debug_only: assert property (sc15_valid && !busy_q && !dbg_s
    |=> !sc15_busy) else $error("chain access taken outside debug"); // [RULE21]

endmodule

// *** src/dvc_core.sv ***
`timescale 1ns/1ps
`include "dvc_defines.svh"
// Core-clock side and top: vector trap, single-step, comms channel
module dvc_core import dvc_pkg::*; #(
  parameter logic [3:0] VERSION = 4'h5  // Version code value is arbitrary
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Scan side, test clock domain
  input  wire logic        tck,
  input  wire logic [4:0]  sc_addr,
  input  wire logic        sc_wr,
  input  wire logic        sc_rd,
  input  wire logic [31:0] sc_wdata,
  output logic      [31:0] sc_rdata,
  input  wire logic        sc15_valid,
  input  wire logic [38:0] sc15_word,
  output logic             sc15_busy,
  output logic             sc15_done,
  output logic      [31:0] sc15_rdata,
  // Coprocessor 14 transfers
  input  wire logic        cp_valid,
  input  wire logic        cp_read,
  input  wire logic [3:0]  cp_crn,
  input  wire logic [3:0]  cp_crm,
  input  wire logic [31:0] cp_wdata,
  input  wire logic        core_narrow,
  output logic      [31:0] cp_rdata,
  output logic             cp_rvalid,
  // Fetch and execution status
  input  wire logic        if_valid,
  input  wire logic        if_exc_entry,
  input  wire logic [31:0] if_addr,
  input  wire logic        instr_done,
  input  wire logic        debug_acknowledge,
  output logic             vector_break,
  output logic             step_break,
  output logic             debug_request,
  output logic             interrupt_disable,
  // Control coprocessor access during debug
  output logic             cp15_req,
  output logic             cp15_we,
  output logic      [5:0]  cp15_addr,
  output logic      [31:0] cp15_wdata,
  input  wire logic [31:0] cp15_rdata,
  // Channel requests
  output logic             outbound_free_request,
  output logic             inbound_data_request
);

  dvc_cross_if cr ();

  // ----------------------------------------
  // Scan-clock domain
  // ----------------------------------------
  dvc_scan #(
    .VERSION (VERSION)
  ) u_scan (
    .tck        (tck),
    .arst_n     (arst_n),
    .cr         (cr.scan),
    .sc_addr    (sc_addr),
    .sc_wr      (sc_wr),
    .sc_rd      (sc_rd),
    .sc_wdata   (sc_wdata),
    .sc_rdata   (sc_rdata),
    .sc15_valid (sc15_valid),
    .sc15_word  (sc15_word),
    .sc15_busy  (sc15_busy),
    .sc15_done  (sc15_done),
    .sc15_rdata (sc15_rdata)
  );

  // ----------------------------------------
  // Crossings into the core clock
  // ----------------------------------------
  // Control fields are quasi-static: the debugger changes ctrl only in debug state and vcatch only between fetches
  logic [14:0] s1_q, s2_q;
  logic [3:0]  ctrl_s;
  logic [7:0]  vc_s;
  logic        rx_set_s, tx_clr_s, req_s;

  // [RULE24] two-stage synchroniser
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 15'h0;
      s2_q <= 15'h0;
    end else begin
      s1_q <= {cr.c15_req_tgl, cr.tx_clr_tgl, cr.rx_set_tgl, cr.vcatch, cr.ctrl};
      s2_q <= s1_q;
    end
  end

  assign ctrl_s   = s2_q[3:0];
  assign vc_s     = s2_q[11:4];
  assign rx_set_s = s2_q[12];
  assign tx_clr_s = s2_q[13];
  assign req_s    = s2_q[14];

  // [RULE23] request and interrupt-disable bits
  assign debug_request     = ctrl_s[`DVC_CTRL_DBG_REQ];
  assign interrupt_disable = ctrl_s[`DVC_CTRL_INT_DIS];
  assign cr.dbg_ack        = debug_acknowledge;

  // ----------------------------------------
  // Vector trap
  // ----------------------------------------
  // Own address compare, independent of comparators; kept combinational so
  // the break lines up with the fetch it belongs to
  logic vec_fetch;

  // [RULE3] only exception-entry fetches
  assign vec_fetch = if_valid && if_exc_entry && (if_addr[31:5] == 27'h0);
  // [RULE1] [RULE2] [RULE4] enabled vector traps fetch
  assign vector_break = vec_fetch && vc_s[if_addr[4:2]];

  // ----------------------------------------
  // Single step
  // ----------------------------------------
  dvc_step_t step_q, step_d;
  logic      step_en;

  // [RULE5] step enable from control bit 3
  assign step_en = ctrl_s[`DVC_CTRL_STEP];

  // Step sequencer; relies on the bit being stable outside debug state
  always_comb begin
    step_d = step_q;
    case (step_q)
      ST_IDLE: begin
        if (debug_acknowledge && step_en) begin
          step_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // [RULE7] bit sampled while in debug
        if (!step_en) begin
          step_d = ST_IDLE;
        end else if (!debug_acknowledge) begin
          step_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // [RULE6] one instruction then break
        if (instr_done) begin
          step_d = ST_BREAK;
        end
      end
      ST_BREAK: begin
        if (debug_acknowledge) begin
          step_d = step_en ? ST_ARMED : ST_IDLE;
        end
      end
      default: step_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_q <= ST_IDLE;
    end else begin
      step_q <= step_d;
    end
  end

  assign step_break = (step_q == ST_BREAK);

  // ----------------------------------------
  // Comms channel, core side
  // ----------------------------------------
  logic [31:0] tx_data_q, tx_data_d, rdata_q, rdata_d;
  logic        tx_set_q, tx_set_d, rx_clr_q, rx_clr_d, rvalid_q, rvalid_d;
  logic        obf_q, obf_d, ibd_q, ibd_d;
  logic        tx_full_c, rx_full_c, cp_ok;

  // [RULE15] flags seen on core clock
  assign tx_full_c = tx_set_q ^ tx_clr_s;
  assign rx_full_c = rx_set_s ^ rx_clr_q;
  // [RULE17] no channel in compressed state
  assign cp_ok     = cp_valid && !core_narrow && (cp_crm == `DVC_CRM_COMMS);

  always_comb begin
    tx_data_d = tx_data_q;
    tx_set_d  = tx_set_q;
    rx_clr_d  = rx_clr_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    // [RULE16] coprocessor 14 decode
    if (cp_ok && cp_read && cp_crn == `DVC_CRN_HS) begin
      // [RULE10] read-only handshake with version
      rdata_d  = dvc_hs_word(VERSION, tx_full_c, rx_full_c);
      rvalid_d = 1'b1;
    end else if (cp_ok && cp_read && cp_crn == `DVC_CRN_DATA) begin
      rdata_d  = cr.rx_data;
      rvalid_d = 1'b1;
      // [RULE14] core read frees inbound
      if (rx_full_c) begin
        rx_clr_d = ~rx_clr_q;
      end
    end else if (cp_ok && !cp_read && cp_crn == `DVC_CRN_DATA && !tx_full_c) begin
      // [RULE11] core write sets outbound-full
      tx_data_d = cp_wdata;
      tx_set_d  = ~tx_set_q;
    end
    // [RULE20] request levels
    obf_d = !tx_full_c;
    ibd_d = rx_full_c;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_data_q <= 32'h0;
      tx_set_q  <= 1'b0;
      rx_clr_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rvalid_q  <= 1'b0;
      obf_q     <= 1'b0;
      ibd_q     <= 1'b0;
    end else begin
      tx_data_q <= tx_data_d;
      tx_set_q  <= tx_set_d;
      rx_clr_q  <= rx_clr_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
      obf_q     <= obf_d;
      ibd_q     <= ibd_d;
    end
  end

  // [RULE9] data registers across the crossing
  assign cr.tx_data             = tx_data_q;
  assign cr.tx_set_tgl          = tx_set_q;
  assign cr.rx_clr_tgl          = rx_clr_q;
  assign cp_rdata               = rdata_q;
  assign cp_rvalid              = rvalid_q;
  assign outbound_free_request  = obf_q;
  assign inbound_data_request   = ibd_q;

  // ----------------------------------------
  // Control coprocessor access, core side
  // ----------------------------------------
  logic        seen_q, seen_d, pend_q, pend_d, ack_q, ack_d, req_q, req_d, we_q, we_d;
  logic [5:0]  adr_q, adr_d;
  logic [31:0] wd_q, wd_d, c15r_q, c15r_d;

  // [RULE21] issue one access, capture answer
  always_comb begin
    seen_d = seen_q;
    pend_d = 1'b0;
    ack_d  = ack_q;
    req_d  = 1'b0;
    we_d   = we_q;
    adr_d  = adr_q;
    wd_d   = wd_q;
    c15r_d = c15r_q;
    if (pend_q) begin
      c15r_d = cp15_rdata;
      ack_d  = ~ack_q;
    end else if (req_s != seen_q) begin
      seen_d = req_s;
      if (debug_acknowledge) begin
        req_d  = 1'b1;
        pend_d = 1'b1;
        we_d   = cr.c15_word[`DVC_C15_RW];
        adr_d  = cr.c15_word[37:32];
        wd_d   = cr.c15_word[31:0];
      end else begin
        c15r_d = 32'h0;
        ack_d  = ~ack_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q <= 1'b0;
      pend_q <= 1'b0;
      ack_q  <= 1'b0;
      req_q  <= 1'b0;
      we_q   <= 1'b0;
      adr_q  <= 6'h0;
      wd_q   <= 32'h0;
      c15r_q <= 32'h0;
    end else begin
      seen_q <= seen_d;
      pend_q <= pend_d;
      ack_q  <= ack_d;
      req_q  <= req_d;
      we_q   <= we_d;
      adr_q  <= adr_d;
      wd_q   <= wd_d;
      c15r_q <= c15r_d;
    end
  end

  assign cp15_req       = req_q;
  assign cp15_we        = we_q;
  assign cp15_addr      = adr_q;
  assign cp15_wdata     = wd_q;
  assign cr.c15_ack_tgl = ack_q;
  assign cr.c15_rdata   = c15r_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_step_leave;
    step_q == ST_ARMED && !debug_acknowledge && step_en;
  endsequence

  a_vec_soft_break: assert property (vec_fetch && if_addr == `DVC_VEC_SOFT_ADDR && vc_s[2]
    |-> vector_break) else $error("soft interrupt vector fetch not trapped"); // [RULE2]
  a_vec_branch_free: assert property (if_valid && !if_exc_entry
    |-> !vector_break) else $error("plain branch trapped"); // [RULE3]
  a_vec_bit_off: assert property (vec_fetch && !vc_s[if_addr[4:2]]
    |-> !vector_break) else $error("disabled vector trapped"); // [RULE1]
  a_step_one_instr: assert property (s_step_leave ##1 instr_done
    |=> step_break) else $error("no break after stepped instruction"); // [RULE6]
  a_step_hold: assert property (step_break && !debug_acknowledge
    |=> step_break) else $error("step break dropped early"); // [RULE6]
  a_tx_set_write: assert property (cp_ok && !cp_read && cp_crn == `DVC_CRN_DATA && !tx_full_c
    |=> tx_full_c ##1 !outbound_free_request) else $error("outbound flag not set"); // [RULE11]
  a_rx_clear_read: assert property (cp_ok && cp_read && cp_crn == `DVC_CRN_DATA && rx_full_c
    |=> !rx_full_c) else $error("inbound flag not cleared"); // [RULE14]
  a_narrow_blocked: assert property (cp_valid && core_narrow
    |=> !cp_rvalid) else $error("transfer taken in compressed state"); // [RULE17]
  a_hs_version: assert property (cp_ok && cp_read && cp_crn == `DVC_CRN_HS
    |=> cp_rdata[31:28] == VERSION && cp_rdata[27:2] == 26'h0)
    else $error("handshake word malformed"); // [RULE10]
  a_req_levels: assert property (##1 inbound_data_request == $past(rx_full_c))
    else $error("inbound request mismatch"); // [RULE20]

endmodule

// *** tb/dvc_host_model.sv ***
`timescale 1ns/1ps
// Host debugger stand-in on the scan register port
module dvc_host_model (
  input  wire logic        tck,
  output logic      [4:0]  sc_addr,
  output logic             sc_wr,
  output logic             sc_rd,
  output logic      [31:0] sc_wdata,
  input  wire logic [31:0] sc_rdata
);
  // Idle port, nothing selected
  initial begin
    sc_addr = 5'h1f;
    sc_wr = 1'b0;
    sc_rd = 1'b0;
    sc_wdata = 32'h0;
  end

  // One-tck write; data inverted once released so stale values never match
  task automatic scan_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge tck);
    #1;
    sc_addr = a;
    sc_wdata = d;
    sc_wr = 1'b1;
    @(posedge tck);
    #1;
    sc_wr = 1'b0;
    sc_wdata = ~d;
  endtask

  // One-tck read, result taken one tck later
  task automatic scan_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge tck);
    #1;
    sc_addr = a;
    sc_rd = 1'b1;
    @(posedge tck);
    #1;
    sc_rd = 1'b0;
    @(posedge tck);
    #1;
    d = sc_rdata;
  endtask

  task automatic scan_send(input logic [31:0] d);
    logic [31:0] hs = 32'h1;
    for (int n = 0; n < 40 && hs[0] !== 1'b0; n++) scan_rd(5'h04, hs);
    scan_wr(5'h05, d);
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`include "dvc_defines.svh"
module tb_top;
  import dvc_pkg::*;
  logic sys_clk = 0, tck = 0, arst_n = 0;
  logic cp_valid = 0, cp_read = 0, core_narrow = 0, got;
  logic [3:0] cp_crn = 0, cp_crm = 0;
  logic [31:0] cp_wdata = 0, rd, d, cp_rdata, sc_rdata, sc_wdata;
  logic if_valid = 0, if_exc_entry = 0, instr_done = 0, debug_acknowledge = 0;
  logic [31:0] if_addr = 0;
  logic [4:0] sc_addr;
  logic sc_wr, sc_rd, cp_rvalid, vector_break, step_break, debug_request;
  logic interrupt_disable, outbound_free_request, inbound_data_request;
  logic sc15_valid = 0, sc15_busy, sc15_done, cp15_req, cp15_we;
  logic [38:0] sc15_word = 0;
  logic [31:0] sc15_rdata, cp15_wdata;
  logic [5:0] cp15_addr;
  int fail_count = 0, cmp_count = 0;

  always #5 sys_clk = ~sys_clk;
  // Link clock, phase unrelated to the core clock
  initial begin
    #1.3;
    forever #3 tck = ~tck;
  end

  dvc_host_model u_dvc_host_model (.tck(tck), .sc_addr(sc_addr), .sc_wr(sc_wr),
    .sc_rd(sc_rd), .sc_wdata(sc_wdata), .sc_rdata(sc_rdata));
  dvc_core u_dvc_core (.sys_clk(sys_clk), .arst_n(arst_n), .tck(tck), .sc_addr(sc_addr),
    .sc_wr(sc_wr), .sc_rd(sc_rd), .sc_wdata(sc_wdata), .sc_rdata(sc_rdata),
    .sc15_valid(sc15_valid), .sc15_word(sc15_word), .sc15_busy(sc15_busy),
    .sc15_done(sc15_done), .sc15_rdata(sc15_rdata),
    .cp_valid(cp_valid), .cp_read(cp_read), .cp_crn(cp_crn), .cp_crm(cp_crm),
    .cp_wdata(cp_wdata), .core_narrow(core_narrow), .cp_rdata(cp_rdata),
    .cp_rvalid(cp_rvalid), .if_valid(if_valid), .if_exc_entry(if_exc_entry),
    .if_addr(if_addr), .instr_done(instr_done), .debug_acknowledge(debug_acknowledge),
    .vector_break(vector_break), .step_break(step_break), .debug_request(debug_request),
    .interrupt_disable(interrupt_disable), .cp15_req(cp15_req), .cp15_we(cp15_we),
    .cp15_addr(cp15_addr), .cp15_wdata(cp15_wdata), .cp15_rdata(~cp15_wdata),
    .outbound_free_request(outbound_free_request),
    .inbound_data_request(inbound_data_request));

  // Expected handshake word, version as instantiated
  function automatic logic [31:0] hs_exp(input logic w, input logic r);
    return {4'h5, 26'h0, w, r};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask

  // Coprocessor transfer; answer read just after the take edge, or one cycle later
  task automatic cp_xfer(input logic r, input logic [3:0] crn, input logic [31:0] wd);
    @(posedge sys_clk);
    #1;
    {cp_valid, cp_read, cp_crn, cp_wdata} = {1'b1, r, crn, wd};
    @(posedge sys_clk);
    #1;
    cp_valid = 1'b0;
    cp_wdata = ~wd;
    {got, rd} = {cp_rvalid, cp_rdata};
    if (got !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      {got, rd} = {cp_rvalid, cp_rdata};
    end
  endtask

  // Bounded wait on a request line
  task automatic wait_req(input logic f, input logic v);
    for (int n = 0; n < 40 && (f ? outbound_free_request : inbound_data_request) !== v; n++)
      @(posedge sys_clk) #1;
  endtask

  // One-tck chain request from the host side
  task automatic c15_pulse(input logic [38:0] w);
    @(posedge tck);
    #1 {sc15_valid, sc15_word} = {1'b1, w};
    @(posedge tck);
    #1 sc15_valid = 1'b0;
  endtask

  task automatic fetch_chk(input logic x, input logic [31:0] a, input logic e);
    @(posedge sys_clk);
    #1;
    {if_valid, if_exc_entry, if_addr} = {1'b1, x, a};
    #1 chk("vector_break", {31'h0, e}, {31'h0, vector_break});
    @(posedge sys_clk);
    #1;
    {if_valid, if_exc_entry, if_addr} = {2'b00, ~a};
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog, well beyond the expected run
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    void'($urandom(59215));
    repeat (6) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("free_req", 1, {31'h0, outbound_free_request});
    cp_xfer(1'b1, 4'h0, 32'h0);
    chk("core_hs", hs_exp(0, 0), rd);
    $display("test reset done");
    // Each trap bit against its own vector, a plain branch, and a neighbour
    for (int i = 0; i < 8; i++) begin
      u_dvc_host_model.scan_wr(`DVC_ADR_VCATCH, 32'(8'h1 << i));
      repeat (12) @(posedge sys_clk);
      u_dvc_host_model.scan_rd(`DVC_ADR_VCATCH, rd);
      chk("vcatch", (i == 5) ? 32'h0 : 32'(8'h1 << i), rd);
      fetch_chk(1'b1, 32'(i * 4), i != 5);
      fetch_chk(1'b0, 32'(i * 4), 1'b0);
      fetch_chk(1'b1, 32'(((i + 1) % 8) * 4), 1'b0);
    end
    $display("test vector done");
    // Step bit set only while in debug state
    #1 debug_acknowledge = 1'b1;
    u_dvc_host_model.scan_wr(`DVC_ADR_CTRL, 32'h8);
    repeat (12) @(posedge sys_clk);
    u_dvc_host_model.scan_rd(`DVC_ADR_CTRL, rd);
    chk("ctrl", 32'h8, rd);
    #1 debug_acknowledge = 1'b0;
    @(posedge sys_clk);
    chk("step_early", 0, {31'h0, step_break});
    #1 instr_done = 1'b1;
    @(posedge sys_clk);
    #1 instr_done = 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("step_break", 1, {31'h0, step_break});
    #1 debug_acknowledge = 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("step_clear", 0, {31'h0, step_break});
    u_dvc_host_model.scan_wr(`DVC_ADR_CTRL, 32'h6);
    repeat (12) @(posedge sys_clk);
    chk("ctl_bits", 3, {30'h0, interrupt_disable, debug_request});
    // Chain write in debug: fields reach the core side, answer comes back
    d = $urandom();
    c15_pulse({1'b1, 6'h05, d});
    for (int n = 0; n < 40 && cp15_req !== 1'b1; n++) @(posedge sys_clk) #1;
    chk("cp15_out", {d[24:0], 1'b1, 6'h05}, {cp15_wdata[24:0], cp15_we, cp15_addr});
    for (int n = 0; n < 40 && sc15_done !== 1'b1; n++) @(posedge tck) #1;
    chk("sc15_rdata", ~d, sc15_rdata);
    chk("sc15_busy", 0, {31'h0, sc15_busy});
    u_dvc_host_model.scan_wr(`DVC_ADR_CTRL, 32'h0);
    #1 debug_acknowledge = 1'b0;
    $display("test step done");
    // Chain request outside debug is refused
    repeat (3) @(posedge sys_clk);
    c15_pulse({1'b0, 6'h01, 32'h0});
    chk("sc15_refused", 0, {31'h0, sc15_busy});
    // Random words both ways; a second core write while full is dropped
    for (int i = 0; i < 4; i++) begin
      d = $urandom();
      wait_req(1'b1, 1'b1);
      cp_xfer(1'b0, `DVC_CRN_DATA, d);
      cp_xfer(1'b0, `DVC_CRN_DATA, ~d);
      wait_req(1'b1, 1'b0);
      chk("free_req", 0, {31'h0, outbound_free_request});
      cp_xfer(1'b1, `DVC_CRN_HS, 32'h0);
      chk("core_hs", hs_exp(1, 0), rd);
      u_dvc_host_model.scan_rd(`DVC_ADR_COMMS_CTL, rd);
      chk("scan_hs", hs_exp(1, 0), rd);
      u_dvc_host_model.scan_rd(`DVC_ADR_COMMS_DATA, rd);
      chk("tx_data", d, rd);
      wait_req(1'b1, 1'b1);
      chk("free_req", 1, {31'h0, outbound_free_request});
      u_dvc_host_model.scan_send(~d);
      wait_req(1'b0, 1'b1);
      chk("data_req", 1, {31'h0, inbound_data_request});
      core_narrow = (i == 2);
      cp_xfer(1'b1, `DVC_CRN_DATA, 32'h0);
      chk("narrow_rvalid", i != 2, {31'h0, got});
      core_narrow = 1'b0;
      cp_xfer(1'b1, `DVC_CRN_DATA, 32'h0);
      chk("rx_data", ~d, rd);
      wait_req(1'b0, 1'b0);
      u_dvc_host_model.scan_rd(`DVC_ADR_COMMS_CTL, rd);
      chk("scan_hs", hs_exp(0, 0), rd);
    end
    $display("test comms done");
    end_sim();
  end
endmodule
